// ===== src/disrc_top.sv
`timescale 1ns/10ps
`default_nettype none

module disrc_top (
    input  wire logic                      clk_sys,
    input  wire logic                      rst,
    // Host register port
    input  wire logic                      reg_rd_en,
    input  wire logic                      reg_wr_en,
    input  wire logic [7:0]                reg_addr,
    output logic      [disrc_pkg::REG_W-1:0] reg_rd_data,
    output logic                           reg_rd_hit,
    // Device state
    input  wire logic                      second_sensor_active,
    input  wire logic                      first_sensor_active,
    input  wire logic                      aux_nack,
    input  wire logic                      wake_state,
    input  wire logic                      gyro_enabled,
    input  wire logic                      gyro_loop_locked,
    input  wire logic                      accel_enabled,
    // Source events
    input  wire logic                      buffer_full,
    input  wire logic                      buffer_watermark,
    input  wire logic                      motion_wake_event,
    input  wire logic                      return_sleep_event,
    input  wire logic                      second_sensor_new,
    input  wire logic                      first_sensor_new,
    input  wire logic                      accel_data_new,
    input  wire logic                      temp_data_new,
    input  wire logic                      rate_data_new,
    input  wire logic [disrc_pkg::DIR_W-1:0] wake_direction,
    // Routing and masking per pin
    input  wire logic [disrc_pkg::REG_W-1:0] pin1_route_mask,
    input  wire logic [disrc_pkg::DIR_W-1:0] pin1_dir_mask,
    input  wire logic [disrc_pkg::REG_W-1:0] pin2_route_mask,
    input  wire logic [disrc_pkg::DIR_W-1:0] pin2_dir_mask,
    // Interrupt pins
    output logic                           pin1_irq_or,
    output logic                           pin2_irq_or
);

    localparam int N = disrc_pkg::PIN_CNT;

    // Per-pin arrays, index 0 is the first pin
    logic [disrc_pkg::REG_W-1:0] route_mask [N];
    logic [disrc_pkg::DIR_W-1:0] dir_mask   [N];
    logic [disrc_pkg::REG_W-1:0] events_q   [N];
    logic [disrc_pkg::DIR_W-1:0] dir_q      [N];
    logic [N-1:0]                irq_or_q;
    logic [N-1:0]                latch_read;
    logic [N-1:0]                status_read;
    logic [N-1:0]                por_q;

    // Shared status state
    logic                        aux_err_q;
    logic                        second_act_q;
    logic                        first_act_q;
    logic                        wake_q;
    logic                        run_q;
    logic                        start_q;

    // Decoded accesses and derived events
    logic                        aux_status_write;
    logic                        rd_rate_low;
    logic                        rd_accel_low;
    logic                        rd_temp_low;
    logic                        rd_first_out1;
    logic                        rd_second_out1;
    logic                        acc_ready_set;
    logic                        acc_ready_clr;
    logic [disrc_pkg::EVT_W-1:0] event_set;
    logic [disrc_pkg::CLR_W-1:0] ready_clr;
    logic [disrc_pkg::REG_W-1:0] status_val [N];
    logic [disrc_pkg::REG_W-1:0] rd_data_d;
    logic                        rd_hit_d;

    assign route_mask[0] = pin1_route_mask;
    assign route_mask[1] = pin2_route_mask;
    assign dir_mask[0]   = pin1_dir_mask;
    assign dir_mask[1]   = pin2_dir_mask;

    // Release and status read strobes, one set per pin
    assign latch_read[0]  = reg_rd_en &
                            (reg_addr == disrc_pkg::ADDR_PIN1_RELEASE);
    assign latch_read[1]  = reg_rd_en &
                            (reg_addr == disrc_pkg::ADDR_PIN2_RELEASE);
    assign status_read[0] = reg_rd_en &
                            (reg_addr == disrc_pkg::ADDR_PIN1_STATUS);
    assign status_read[1] = reg_rd_en &
                            (reg_addr == disrc_pkg::ADDR_PIN2_STATUS);

    // Reads of output bytes elsewhere in the map that clear ready flags, and the aux status write that clears aux error
    assign rd_rate_low    = reg_rd_en &
                            (reg_addr == disrc_pkg::ADDR_RATE_X_LOW);
    assign rd_accel_low   = reg_rd_en &
                            (reg_addr == disrc_pkg::ADDR_ACCEL_X_LOW);
    assign rd_temp_low    = reg_rd_en &
                            (reg_addr == disrc_pkg::ADDR_TEMP_LOW);
    assign rd_first_out1  = reg_rd_en &
                            (reg_addr == disrc_pkg::ADDR_FIRST_OUT1);
    assign rd_second_out1 = reg_rd_en &
                            (reg_addr == disrc_pkg::ADDR_SECOND_OUT1);
    assign aux_status_write = reg_wr_en &
                              (reg_addr == disrc_pkg::ADDR_AUX_STATUS);

    // Temperature shares the accel ready bit; it only speaks alone
    // while the accelerometer is off, otherwise it rides with accel data
    assign acc_ready_set = accel_enabled ? accel_data_new
                                         : temp_data_new;
    assign acc_ready_clr = rd_accel_low |
                           (~accel_enabled & rd_temp_low);

    // Set pulses in first-source bit order, bits 5 down to 0
    assign event_set = {motion_wake_event,
                        return_sleep_event,
                        second_sensor_new,
                        first_sensor_new,
                        acc_ready_set,
                        rate_data_new};

    // Per-bit clears for the four data-ready flags
    assign ready_clr = {rd_second_out1,
                        rd_first_out1,
                        acc_ready_clr,
                        rd_rate_low};

    // One source block per pin; each has its own release read
    genvar p;
    generate
        for (p = 0; p < N; p = p + 1) begin : g_pin
            disrc_pin_sources u_src (
                .clk_sys    (clk_sys),
                .rst        (rst),
                .buf_full   (buffer_full),
                .watermark  (buffer_watermark),
                .event_set  (event_set),
                .ready_clr  (ready_clr),
                .dir_set    (wake_direction),
                .latch_read (latch_read[p]),
                .route_mask (route_mask[p]),
                .dir_mask   (dir_mask[p]),
                .events_q   (events_q[p]),
                .dir_q      (dir_q[p]),
                .irq_or_q   (irq_or_q[p])
            );
        end
    endgenerate

    // Pins come straight from the source blocks' registered OR
    assign pin1_irq_or = irq_or_q[0];
    assign pin2_irq_or = irq_or_q[1];

    // Reset indicator: loads as 1 with the reset value, each status
    // register loses its own copy when it is read
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            por_q <= {N{disrc_pkg::STATUS_RESET[disrc_pkg::STAT_POR_BIT]}};
        end else begin
            por_q <= por_q & ~status_read;
        end
    end

    // Aux error is sticky; a new missing ack beats the clearing write
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            aux_err_q <= disrc_pkg::STATUS_RESET[disrc_pkg::STAT_AUX_ERR_BIT];
        end else begin
            aux_err_q <= aux_nack | (aux_err_q & ~aux_status_write);
        end
    end

    // Live state fields sampled each cycle; start shows only while the
    // gyro is on and has not locked, so a stuck start flags a fault
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            second_act_q <=
                disrc_pkg::STATUS_RESET[disrc_pkg::STAT_SECOND_ACT_BIT];
            first_act_q  <=
                disrc_pkg::STATUS_RESET[disrc_pkg::STAT_FIRST_ACT_BIT];
            wake_q       <= disrc_pkg::STATUS_RESET[disrc_pkg::STAT_WAKE_BIT];
            run_q        <= disrc_pkg::STATUS_RESET[disrc_pkg::STAT_RUN_BIT];
            start_q      <= disrc_pkg::STATUS_RESET[disrc_pkg::STAT_START_BIT];
        end else begin
            second_act_q <= second_sensor_active;
            first_act_q  <= first_sensor_active;
            wake_q       <= wake_state;
            run_q        <= gyro_enabled & gyro_loop_locked;
            start_q      <= gyro_enabled & ~gyro_loop_locked;
        end
    end

    // Status images; only the OR and reset bits differ between pins
    generate
        for (p = 0; p < N; p = p + 1) begin : g_stat
            always_comb begin
                status_val[p] = disrc_pkg::UNMAPPED_VALUE;
                status_val[p][disrc_pkg::STAT_IRQ_BIT]   = irq_or_q[p];
                status_val[p][disrc_pkg::STAT_POR_BIT]   = por_q[p];
                status_val[p][disrc_pkg::STAT_SECOND_ACT_BIT] = second_act_q;
                status_val[p][disrc_pkg::STAT_FIRST_ACT_BIT]  = first_act_q;
                status_val[p][disrc_pkg::STAT_AUX_ERR_BIT] = aux_err_q;
                status_val[p][disrc_pkg::STAT_WAKE_BIT]  = wake_q;
                status_val[p][disrc_pkg::STAT_RUN_BIT]   = run_q;
                status_val[p][disrc_pkg::STAT_START_BIT] = start_q;
            end
        end
    endgenerate

    // Read mux; the value returned is the one before any clear-on-read
    always_comb begin
        rd_data_d = disrc_pkg::UNMAPPED_VALUE;
        rd_hit_d  = reg_rd_en;
        case (reg_addr)
            disrc_pkg::ADDR_PIN1_STATUS:  rd_data_d = status_val[0];
            disrc_pkg::ADDR_PIN1_EVENTS:  rd_data_d = events_q[0];
            disrc_pkg::ADDR_PIN1_DIR:
                rd_data_d = {disrc_pkg::DIR_PAD, dir_q[0]};
            disrc_pkg::ADDR_PIN1_RELEASE:
                rd_data_d = disrc_pkg::RELEASE_VALUE;
            disrc_pkg::ADDR_PIN2_STATUS:  rd_data_d = status_val[1];
            disrc_pkg::ADDR_PIN2_EVENTS:  rd_data_d = events_q[1];
            disrc_pkg::ADDR_PIN2_DIR:
                rd_data_d = {disrc_pkg::DIR_PAD, dir_q[1]};
            disrc_pkg::ADDR_PIN2_RELEASE:
                rd_data_d = disrc_pkg::RELEASE_VALUE;
            default: begin
                // Other addresses belong to other blocks of the device
                rd_data_d = disrc_pkg::UNMAPPED_VALUE;
                rd_hit_d  = 1'b0;
            end
        endcase
    end

    // Registered read answer, one cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rd_data <= disrc_pkg::UNMAPPED_VALUE;
            reg_rd_hit  <= 1'b0;
        end else begin
            reg_rd_data <= rd_data_d;
            reg_rd_hit  <= rd_hit_d;
        end
    end

endmodule // disrc_top

`default_nettype wire

// ===== shared/disrc_pkg.sv
package disrc_pkg;

    // Data and field widths
    localparam int REG_W   = 8;
    localparam int EVT_W   = 6;
    localparam int DIR_W   = 6;
    localparam int CLR_W   = 4;
    localparam int PIN_CNT = 2;

    // Register offsets of this block
    localparam logic [7:0] ADDR_PIN1_STATUS   = 8'h36;
    localparam logic [7:0] ADDR_PIN1_EVENTS   = 8'h37;
    localparam logic [7:0] ADDR_PIN1_DIR      = 8'h38;
    localparam logic [7:0] ADDR_PIN1_RELEASE  = 8'h39;
    localparam logic [7:0] ADDR_PIN2_STATUS   = 8'h3A;
    localparam logic [7:0] ADDR_PIN2_EVENTS   = 8'h3B;
    localparam logic [7:0] ADDR_PIN2_DIR      = 8'h3C;
    localparam logic [7:0] ADDR_PIN2_RELEASE  = 8'h3D;

    // Neighbouring registers whose access clears flags here
    localparam logic [7:0] ADDR_RATE_X_LOW    = 8'h00;
    localparam logic [7:0] ADDR_ACCEL_X_LOW   = 8'h06;
    localparam logic [7:0] ADDR_FIRST_OUT1    = 8'h0E;
    localparam logic [7:0] ADDR_SECOND_OUT1   = 8'h14;
    localparam logic [7:0] ADDR_AUX_STATUS    = 8'h22;
    localparam logic [7:0] ADDR_TEMP_LOW      = 8'h2E;

    // Status register fields
    localparam int STAT_IRQ_BIT        = 7;
    localparam int STAT_POR_BIT        = 6;
    localparam int STAT_SECOND_ACT_BIT = 5;
    localparam int STAT_FIRST_ACT_BIT  = 4;
    localparam int STAT_AUX_ERR_BIT    = 3;
    localparam int STAT_WAKE_BIT       = 2;
    localparam int STAT_RUN_BIT        = 1;
    localparam int STAT_START_BIT      = 0;

    // First source register fields
    localparam int SRC_BUF_FULL_BIT    = 7;
    localparam int SRC_WATERMARK_BIT   = 6;
    localparam int SRC_WAKE_BIT        = 5;
    localparam int SRC_SLEEP_BIT       = 4;
    localparam int SRC_SECOND_RDY_BIT  = 3;
    localparam int SRC_FIRST_RDY_BIT   = 2;
    localparam int SRC_ACC_RDY_BIT     = 1;
    localparam int SRC_RATE_RDY_BIT    = 0;

    // Reset and fixed read values
    localparam logic [7:0] STATUS_RESET   = 8'h44;
    localparam logic [7:0] SOURCE_RESET   = 8'h00;
    localparam logic [5:0] DIR_RESET      = 6'h00;
    localparam logic [7:0] RELEASE_VALUE  = 8'h00;
    localparam logic [7:0] UNMAPPED_VALUE = 8'h00;
    localparam logic [1:0] DIR_PAD        = 2'h0;

endpackage

// ===== src/disrc_pin_sources.sv
`timescale 1ns/10ps
`default_nettype none

module disrc_pin_sources (
    input  wire logic                     clk_sys,
    input  wire logic                     rst,
    input  wire logic                     buf_full,
    input  wire logic                     watermark,
    input  wire logic [disrc_pkg::EVT_W-1:0] event_set,
    input  wire logic [disrc_pkg::CLR_W-1:0] ready_clr,
    input  wire logic [disrc_pkg::DIR_W-1:0] dir_set,
    input  wire logic                     latch_read,
    input  wire logic [disrc_pkg::REG_W-1:0] route_mask,
    input  wire logic [disrc_pkg::DIR_W-1:0] dir_mask,
    output logic      [disrc_pkg::REG_W-1:0] events_q,
    output logic      [disrc_pkg::DIR_W-1:0] dir_q,
    output logic                          irq_or_q
);

    logic [disrc_pkg::REG_W-1:0] events_d;
    logic [disrc_pkg::DIR_W-1:0] dir_d;
    logic [disrc_pkg::EVT_W-1:0] clr_all;
    logic                        full_prev_q;
    logic                        mark_prev_q;

    // Buffer levels delayed one cycle for edge detection
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            full_prev_q <= 1'b0;
            mark_prev_q <= 1'b0;
        end else begin
            full_prev_q <= buf_full;
            mark_prev_q <= watermark;
        end
    end

    // Only data-ready bits have a per-bit clear; event bits wait for release
    assign clr_all = {2'b00, ready_clr};

    // Level flags: dropped when the condition ends or on release; a new
    // rising edge in the release cycle keeps the flag, so it is not lost
    assign events_d[disrc_pkg::SRC_BUF_FULL_BIT] = buf_full &
        ((events_q[disrc_pkg::SRC_BUF_FULL_BIT] & ~latch_read) |
         ~full_prev_q);
    assign events_d[disrc_pkg::SRC_WATERMARK_BIT] = watermark &
        ((events_q[disrc_pkg::SRC_WATERMARK_BIT] & ~latch_read) |
         ~mark_prev_q);

    // Sticky event flags; set wins over any clear in the same cycle
    genvar i;
    generate
        for (i = 0; i < disrc_pkg::EVT_W; i = i + 1) begin : g_evt
            assign events_d[i] = event_set[i] |
                (events_q[i] & ~latch_read & ~clr_all[i]);
        end
        for (i = 0; i < disrc_pkg::DIR_W; i = i + 1) begin : g_dir
            assign dir_d[i] = dir_set[i] | (dir_q[i] & ~latch_read);
        end
    endgenerate

    // Source registers, both cleared by this pin's release read
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            events_q <= disrc_pkg::SOURCE_RESET;
            dir_q    <= disrc_pkg::DIR_RESET;
        end else begin
            events_q <= events_d;
            dir_q    <= dir_d;
        end
    end

    // Pin follows the next source values so it rises with the flag itself
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_or_q <= 1'b0;
        end else begin
            irq_or_q <= (|(events_d & route_mask)) |
                        (|(dir_d & dir_mask));
        end
    end

endmodule // disrc_pin_sources

`default_nettype wire

// ===== sim/disrc_checker.sv
`timescale 1ns/10ps
`default_nettype none

module disrc_checker (
    input wire logic                          clk_sys,
    input wire logic                          rst,
    input wire logic                          reg_rd_en,
    input wire logic                          reg_wr_en,
    input wire logic [7:0]                    reg_addr,
    input wire logic [disrc_pkg::REG_W-1:0]   reg_rd_data,
    input wire logic                          reg_rd_hit,
    input wire logic                          aux_nack,
    input wire logic                          buffer_full,
    input wire logic                          buffer_watermark,
    input wire logic                          motion_wake_event,
    input wire logic                          return_sleep_event,
    input wire logic                          accel_data_new,
    input wire logic                          temp_data_new,
    input wire logic                          rate_data_new,
    input wire logic [disrc_pkg::DIR_W-1:0]   wake_direction,
    input wire logic [disrc_pkg::REG_W-1:0]   pin1_route_mask,
    input wire logic [disrc_pkg::DIR_W-1:0]   pin1_dir_mask,
    input wire logic [disrc_pkg::REG_W-1:0]   pin2_route_mask,
    input wire logic [disrc_pkg::DIR_W-1:0]   pin2_dir_mask,
    input wire logic                          pin1_irq_or,
    input wire logic                          pin2_irq_or
);
    // Release with only sticky wake flags routed and nothing new arriving
    logic quiet_rel;
    assign quiet_rel = pin1_route_mask == 8'h30 && !motion_wake_event
                       && !return_sleep_event && wake_direction == 6'h00;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    a_status_or: assert property (reg_rd_en && reg_addr == 8'h36
        |=> reg_rd_data[7] == $past(pin1_irq_or)) else $error("pin1 OR bit");
    a_pin2_status_or: assert property (reg_rd_en && reg_addr == 8'h3A
        |=> reg_rd_data[7] == $past(pin2_irq_or)) else $error("pin2 OR bit");
    a_release_zero: assert property (reg_rd_en && reg_addr == 8'h39
        |=> reg_rd_hit && reg_rd_data == 8'h00) else $error("release answer");
    a_release_drop: assert property (reg_rd_en && reg_addr == 8'h39
        && quiet_rel |=> !pin1_irq_or) else $error("pin1 kept after release");
    a_wake_pin: assert property (motion_wake_event
        && pin1_route_mask[5] |=> pin1_irq_or) else $error("wake not on pin1");
    a_sleep_pin: assert property (return_sleep_event
        && pin2_route_mask[4] |=> pin2_irq_or) else $error("sleep not on pin2");
    a_full_drop: assert property ($fell(buffer_full)
        && pin1_route_mask == 8'h80 && pin1_dir_mask == 6'h00
        |-> ##[1:2] !pin1_irq_or) else $error("full flag kept");
    a_mark_drop: assert property ($fell(buffer_watermark)
        && pin2_route_mask == 8'h40 && pin2_dir_mask == 6'h00
        |-> ##[1:2] !pin2_irq_or) else $error("watermark flag kept");
    a_rate_clear: assert property (reg_rd_en && reg_addr == 8'h00
        && !rate_data_new && pin1_route_mask == 8'h01 |=> !pin1_irq_or)
        else $error("rate ready kept");
    a_accel_clear: assert property (reg_rd_en && reg_addr == 8'h06
        && !accel_data_new && !temp_data_new && pin1_route_mask == 8'h02
        |=> !pin1_irq_or) else $error("accel ready kept");
    a_aux_clear: assert property (reg_wr_en && reg_addr == 8'h22
        && !aux_nack ##2 reg_rd_en && reg_addr == 8'h36 && !aux_nack
        |=> !reg_rd_data[3]) else $error("aux error kept");
endmodule // disrc_checker

`default_nettype wire

// ===== sim/disrc_host_model.sv
`timescale 1ns/10ps
`default_nettype none

module disrc_host_model (
    input  wire logic       clk_sys,
    output var  logic       reg_rd_en,
    output var  logic       reg_wr_en,
    output var  logic [7:0] reg_addr,
    input  wire logic [7:0] reg_rd_data,
    input  wire logic       reg_rd_hit
);
    // Idle bus at time zero
    initial begin
        reg_rd_en = 1'b0;
        reg_wr_en = 1'b0;
        reg_addr  = 8'hFF;
    end

    // One read; flags are taken raw, the caller rides out brief ones
    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output logic h);
        @(negedge clk_sys);
        reg_rd_en = 1'b1;
        reg_addr  = a;
        @(negedge clk_sys);
        reg_rd_en = 1'b0;
        reg_addr  = ~a; // Released address never shows the last value
        d = reg_rd_data;
        h = reg_rd_hit;
    endtask

    // One write; the value itself is of no interest to this block
    task automatic wr(input logic [7:0] a);
        @(negedge clk_sys);
        reg_wr_en = 1'b1;
        reg_addr  = a;
        @(negedge clk_sys);
        reg_wr_en = 1'b0;
        reg_addr  = ~a;
    endtask
endmodule // disrc_host_model

`default_nettype wire

// ===== sim/tb_dual_interrupt_status_sources.sv
`timescale 1ns/10ps
`default_nettype none

module tb_dual_interrupt_status_sources;
    logic       clk_sys;
    logic       rst;
    logic       reg_rd_en;
    logic       reg_wr_en;
    logic [7:0] reg_addr;
    logic [7:0] reg_rd_data;
    logic       reg_rd_hit;
    logic [5:0] st;    // sec act, first act, wake, gyro en, lock, acc en
    logic [7:0] ev;    // nack, wake, sleep, temp, second, first, acc, rate
    logic [5:0] wdir;
    logic       buf_full;
    logic       buf_wm;
    logic [7:0] m1;
    logic [5:0] d1;
    logic [5:0] d2;
    logic [7:0] m2;
    logic       pin1_irq_or;
    logic       pin2_irq_or;
    logic [7:0] d;
    logic       h;
    logic [5:0] p;
    logic [7:0] clr [4] = '{8'h00, 8'h06, 8'h0E, 8'h14};
    int         error_cnt = 0;
    int         n_checks = 0;

    disrc_top dut_u (
        .clk_sys(clk_sys), .rst(rst), .reg_rd_en(reg_rd_en),
        .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
        .reg_rd_data(reg_rd_data), .reg_rd_hit(reg_rd_hit),
        .second_sensor_active(st[5]), .first_sensor_active(st[4]),
        .aux_nack(ev[7]), .wake_state(st[3]), .gyro_enabled(st[2]),
        .gyro_loop_locked(st[1]), .accel_enabled(st[0]),
        .buffer_full(buf_full), .buffer_watermark(buf_wm),
        .motion_wake_event(ev[6]), .return_sleep_event(ev[5]),
        .second_sensor_new(ev[3]), .first_sensor_new(ev[2]),
        .accel_data_new(ev[1]), .temp_data_new(ev[4]),
        .rate_data_new(ev[0]), .wake_direction(wdir),
        .pin1_route_mask(m1), .pin1_dir_mask(d1),
        .pin2_route_mask(m2), .pin2_dir_mask(d2),
        .pin1_irq_or(pin1_irq_or), .pin2_irq_or(pin2_irq_or)
    );

    disrc_host_model host_u (
        .clk_sys(clk_sys), .reg_rd_en(reg_rd_en), .reg_wr_en(reg_wr_en),
        .reg_addr(reg_addr), .reg_rd_data(reg_rd_data),
        .reg_rd_hit(reg_rd_hit)
    );

    // Free-running system clock
    initial clk_sys = 1'b0;
    always #20 clk_sys = ~clk_sys;

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // Read and compare in one go
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] rd;
        logic       hit;
        host_u.rd(a, rd, hit);
        chk(rd, e);
    endtask

    // Pulses last exactly one cycle, launched off the falling edge
    task automatic pulse(input logic [7:0] v, input logic [5:0] dv);
        @(negedge clk_sys);
        ev   = v;
        wdir = dv;
        @(negedge clk_sys);
        ev   = 8'h00;
        wdir = 6'h00;
    endtask

    task automatic pins(input logic [1:0] e);
        chk({6'h00, pin2_irq_or, pin1_irq_or}, {6'h00, e});
    endtask

    task automatic end_of_test;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Whole run is well under a thousand cycles
    initial begin
        #(40 * 5000);
        error_cnt++;
        end_of_test();
    end

    initial begin
        rst = 1'b1;
        st = 6'b001001;
        ev = 8'h00;
        wdir = 6'h00;
        buf_full = 1'b0;
        buf_wm = 1'b0;
        m1 = 8'h30;
        d1 = 6'h3F;
        d2 = 6'h3F;
        m2 = 8'h10;
        repeat (20) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        // Reset flag and device state bits
        rdc(8'h36, 8'h44);
        rdc(8'h36, 8'h04);
        rdc(8'h3A, 8'h44);
        st = 6'b110101;
        pulse(8'h80, 6'h00);
        rdc(8'h36, 8'h39);
        st = 6'b110111;
        rdc(8'h3A, 8'h3A);
        host_u.wr(8'h22);
        rdc(8'h36, 8'h32);
        rdc(8'h22, 8'h00);
        st = 6'b001111;
        rdc(8'h36, 8'h06);
        // Sticky wake events, directions and latch release per pin
        for (int i = 0; i < 2; i++) begin
            p = (i == 0) ? 6'h2A : 6'h15;
            pulse(8'h60, p);
            pins(2'b11);
            rdc(8'h37, 8'h30);
            rdc(8'h38, {2'h0, p});
            rdc(8'h36, 8'h86);
            rdc(8'h3A, 8'h86);
            host_u.rd(8'h39, d, h);
            chk(d, 8'h00);
            chk({7'h00, h}, 8'h01);
            pins(2'b10);
            rdc(8'h37, 8'h00);
            rdc(8'h38, 8'h00);
            rdc(8'h3B, 8'h30);
            rdc(8'h3D, 8'h00);
            rdc(8'h3B, 8'h00);
            rdc(8'h3C, 8'h00);
            // A direction alone reaches both pins through their masks
            pulse(8'h00, 6'h01);
            pins(2'b11);
            rdc(8'h3C, 8'h01);
            host_u.rd(8'h39, d, h);
            host_u.rd(8'h3D, d, h);
            pins(2'b00);
        end
        // Data-ready flags and the reads that clear them; pin2 masked
        d1 = 6'h00;
        d2 = 6'h00;
        m2 = 8'h00;
        for (int i = 0; i < 4; i++) begin
            m1 = 8'h01 << i;
            pulse(8'h01 << i, 6'h00);
            pins(2'b01);
            rdc(8'h37, 8'h01 << i);
            host_u.rd(clr[i], d, h);
            pins(2'b00);
            rdc(8'h3B, 8'h00);
        end
        // Shared accel/temperature ready bit
        m1 = 8'h02;
        st = 6'b001110;
        pulse(8'h10, 6'h00);
        rdc(8'h37, 8'h02);
        host_u.rd(8'h2E, d, h);
        rdc(8'h37, 8'h00);
        st = 6'b001111;
        pulse(8'h10, 6'h00);
        rdc(8'h37, 8'h00);
        pulse(8'h02, 6'h00);
        host_u.rd(8'h2E, d, h);
        rdc(8'h37, 8'h02);
        host_u.rd(8'h06, d, h);
        // Buffer level flags
        m1 = 8'h80;
        m2 = 8'h40;
        buf_full = 1'b1;
        buf_wm = 1'b1;
        @(negedge clk_sys);
        pins(2'b11);
        rdc(8'h37, 8'hC0);
        host_u.rd(8'h39, d, h);
        rdc(8'h37, 8'h00);
        buf_wm = 1'b0;
        rdc(8'h3B, 8'h80);
        buf_full = 1'b0;
        rdc(8'h3B, 8'h00);
        buf_full = 1'b1;
        rdc(8'h37, 8'h80);
        buf_full = 1'b0;
        rdc(8'h37, 8'h00);
        // Address outside the block
        host_u.rd(8'h50, d, h);
        chk(d, 8'h00);
        chk({7'h00, h}, 8'h00);
        end_of_test();
    end
endmodule // tb_dual_interrupt_status_sources

bind disrc_top disrc_checker chk_u (
    .clk_sys(clk_sys), .rst(rst), .reg_rd_en(reg_rd_en),
    .reg_wr_en(reg_wr_en), .reg_addr(reg_addr), .reg_rd_data(reg_rd_data),
    .reg_rd_hit(reg_rd_hit), .aux_nack(aux_nack), .buffer_full(buffer_full),
    .buffer_watermark(buffer_watermark),
    .motion_wake_event(motion_wake_event),
    .return_sleep_event(return_sleep_event),
    .accel_data_new(accel_data_new), .temp_data_new(temp_data_new),
    .rate_data_new(rate_data_new), .wake_direction(wake_direction),
    .pin1_route_mask(pin1_route_mask), .pin1_dir_mask(pin1_dir_mask),
    .pin2_route_mask(pin2_route_mask), .pin2_dir_mask(pin2_dir_mask),
    .pin1_irq_or(pin1_irq_or), .pin2_irq_or(pin2_irq_or)
);

`default_nettype wire
